// *** logic/motion_objects_pkg.sv ***
// Package: object indices, subindices, field positions and reset values of the
// motion parameter object bank.
// Assumes: index/subindex addressing by a fieldbus object access engine.
package motion_objects_pkg;

  localparam logic [15:0] IDX_JERK_GROUP = 16'h60a4;
  localparam logic [15:0] IDX_POS_UNIT = 16'h60a8;
  localparam logic [15:0] IDX_VEL_UNIT = 16'h60a9;
  localparam logic [15:0] IDX_POS_OFFSET = 16'h60b0;
  localparam logic [15:0] IDX_SPEED_OFFSET = 16'h60b1;
  localparam logic [15:0] IDX_TORQUE_OFFSET = 16'h60b2;
  localparam logic [15:0] IDX_INTERP_RECORD = 16'h60c1;

  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_FIRST = 8'h01;

  localparam logic [7:0] JERK_COUNT = 8'h04;
  localparam logic [7:0] INTERP_COUNT = 8'h01;
  localparam logic [31:0] JERK_RESET = 32'h000003e8;
  localparam logic [31:0] POS_UNIT_RESET = 32'hff410000;
  localparam logic [31:0] VEL_UNIT_RESET = 32'h00b44700;
  localparam logic [31:0] OFFSET32_RESET = 32'h00000000;
  localparam logic [15:0] TORQUE_OFFSET_RESET = 16'h0000;
  localparam logic [31:0] SETPOINT_RESET = 32'h00000000;

  // Writable bits of the unit words; reserved low bits stay zero
  localparam logic [31:0] POS_UNIT_MASK = 32'hffff0000;
  localparam logic [31:0] VEL_UNIT_MASK = 32'hffffff00;

  localparam int unsigned POS_UNIT_CODE_LSB = 16;
  localparam int unsigned POS_EXP_LSB = 24;
  localparam int unsigned VEL_TIME_CODE_LSB = 8;

  // Access answers
  typedef enum logic [1:0] {
    ANS_OK = 2'h0,
    ANS_NO_OBJECT = 2'h1,
    ANS_READ_ONLY = 2'h2,
    ANS_NOT_MAPPABLE = 2'h3
  } answer_t;

endpackage : motion_objects_pkg

// *** logic/jerk_limit.sv ***
// One jerk limit entry: stored value, with zero turned into unlimited.
// Assumes: write strobe and data from the object bank on the same clock.
`timescale 1ns/100ps
module jerk_limit
  import motion_objects_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  output logic [31:0] value,
  output logic unlimited
);

  typedef struct packed {
    logic [31:0] value;
    logic unlimited;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wrEn) begin
      st_nxt.value = wrData;
      st_nxt.unlimited = (wrData == 32'h00000000);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '{value: JERK_RESET, unlimited: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign value = st_r.value;
  assign unlimited = st_r.unlimited;

  zero_unlimited_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    wrEn |=> (unlimited == (value == 32'h00000000)))
    else $error("jerk zero not flagged unlimited");

endmodule : jerk_limit

// *** logic/setpoint_holder.sv ***
// Interpolation set-point: written value waits, adopted at the sync instant.
// Assumes: syncPulse is a one-cycle pulse on clk_sys.
`timescale 1ns/100ps
module setpoint_holder
  import motion_objects_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wrEn,
  input wire logic [31:0] wrData,
  input wire logic syncPulse,
  output logic [31:0] pending,
  output logic [31:0] active
);

  typedef struct packed {
    logic [31:0] pending;
    logic [31:0] active;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wrEn) begin
      st_nxt.pending = wrData;
    end
    if (syncPulse) begin
      st_nxt.active = wrEn ? wrData : st_r.pending;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '{pending: SETPOINT_RESET, active: SETPOINT_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pending = st_r.pending;
  assign active = st_r.active;

  sequence writeNoSync_s;
    wrEn && !syncPulse;
  endsequence

  hold_until_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !syncPulse |=> $stable(active))
    else $error("set-point adopted without sync");

  adopt_at_sync_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    writeNoSync_s ##1 (syncPulse && !wrEn) |=> active == $past(wrData, 2))
    else $error("set-point not adopted at sync");

endmodule : setpoint_holder

// *** logic/motion_parameter_objects.sv ***
// Motion parameter object bank: jerk limits, unit words, set-value offsets and
// the interpolation set-point, reached by object index and subindex.
// Assumes: a fieldbus object engine on clk_sys issues one-cycle read/write
// strobes (service data) and one-cycle process data writes for mapped objects.
// Operation
// - The jerk group reports a read-only count of four entries.
// - Jerk entry one holds the starting acceleration jerk, reset 1000, writable.
// - Jerk entry two holds the starting braking jerk, reset 1000.
// - Jerk entry three holds the final acceleration jerk, reset 1000.
// - Jerk entry four holds the final braking jerk, reset 1000.
// - The position unit word has its unit in bits 16-23, exponent in 24-31, low bits zero.
// - The velocity unit word has time unit 8-15, position unit 16-23, exponent 24-31.
// - A signed 32-bit position offset, reset zero, is added to the position set value.
// - A signed 32-bit speed offset, reset zero, is added to the speed set value.
// - A signed 16-bit torque offset in tenths of a percent, reset zero.
// - The three offsets take process data writes; jerk entries refuse them.
// - The interpolation record counts one signed 32-bit set-point, writable and mappable.
// - A new set-point takes effect only at the next synchronisation instant.
// - A jerk of zero means unlimited jerk.
`timescale 1ns/100ps
module motion_parameter_objects
  import motion_objects_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic objRead,
  input wire logic objWrite,
  input wire logic [15:0] objIndex,
  input wire logic [7:0] objSubindex,
  input wire logic [31:0] objWrData,
  input wire logic pdoWrite,
  input wire logic [15:0] pdoIndex,
  input wire logic [7:0] pdoSubindex,
  input wire logic [31:0] pdoWrData,
  input wire logic syncPulse,
  input wire logic [31:0] positionSet,
  input wire logic [31:0] speedSet,
  input wire logic [15:0] torqueSet,
  output logic objAck,
  output logic [31:0] objRdData,
  output logic [1:0] objAnswer,
  output logic pdoAck,
  output logic [1:0] pdoAnswer,
  output logic [31:0] jerkAccelStart,
  output logic [31:0] jerkBrakeStart,
  output logic [31:0] jerkAccelEnd,
  output logic [31:0] jerkBrakeEnd,
  output logic [3:0] jerkUnlimited,
  output logic [7:0] posUnitCode,
  output logic [7:0] posExponent,
  output logic [7:0] velTimeCode,
  output logic [7:0] velPosCode,
  output logic [7:0] velExponent,
  output logic [31:0] positionDemand,
  output logic [31:0] speedDemand,
  output logic [15:0] torqueDemand,
  output logic [31:0] interpDemand
);

  typedef struct packed {
    logic [31:0] posUnit;
    logic [31:0] velUnit;
    logic [31:0] posOffset;
    logic [31:0] speedOffset;
    logic [15:0] torqueOffset;
    logic ack;
    logic [31:0] rdData;
    logic [1:0] answer;
    logic pAck;
    logic [1:0] pAnswer;
    logic [31:0] posDemand;
    logic [31:0] spdDemand;
    logic [15:0] trqDemand;
    logic [31:0] ipDemand;
    logic [3:0] jerkUnl;
    logic [31:0] jerk0;
    logic [31:0] jerk1;
    logic [31:0] jerk2;
    logic [31:0] jerk3;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  logic [31:0] jerkVal [4];
  logic [3:0] jerkUnl;
  logic [3:0] jerkWr;
  logic spWrSdo;
  logic spWrPdo;
  logic [31:0] spPending;
  logic [31:0] spActive;
  logic [31:0] posSum;
  logic [31:0] spdSum;
  logic [15:0] trqSum;

  // Service data write to a jerk entry, subindex 1..4
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      jerkWr[i] = objWrite && (objIndex == IDX_JERK_GROUP)
        && (objSubindex == 8'(i + 1));
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gJerk
      jerk_limit uJerk (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wrEn(jerkWr[g]),
        .wrData(objWrData),
        .value(jerkVal[g]),
        .unlimited(jerkUnl[g])
      );
    end
  endgenerate

  assign spWrSdo = objWrite && (objIndex == IDX_INTERP_RECORD) && (objSubindex == SUB_FIRST);
  assign spWrPdo = pdoWrite && (pdoIndex == IDX_INTERP_RECORD) && (pdoSubindex == SUB_FIRST);

  setpoint_holder uSetpoint (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wrEn(spWrSdo || spWrPdo),
    .wrData(spWrPdo ? pdoWrData : objWrData),
    .syncPulse(syncPulse),
    .pending(spPending),
    .active(spActive)
  );

  assign posSum = positionSet + st_r.posOffset;
  assign spdSum = speedSet + st_r.speedOffset;
  assign trqSum = torqueSet + st_r.torqueOffset;

  always_comb begin
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.pAck = 1'b0;
    st_nxt.posDemand = posSum;
    st_nxt.spdDemand = spdSum;
    st_nxt.trqDemand = trqSum;
    st_nxt.ipDemand = spActive;
    st_nxt.jerkUnl = jerkUnl;
    st_nxt.jerk0 = jerkVal[0];
    st_nxt.jerk1 = jerkVal[1];
    st_nxt.jerk2 = jerkVal[2];
    st_nxt.jerk3 = jerkVal[3];

    if (objRead || objWrite) begin
      st_nxt.ack = 1'b1;
      st_nxt.answer = ANS_OK;
      st_nxt.rdData = 32'h00000000;
      case (objIndex)
        IDX_JERK_GROUP: begin
          if (objSubindex == SUB_COUNT) begin
            st_nxt.rdData = {24'h000000, JERK_COUNT};
            if (objWrite) begin
              st_nxt.answer = ANS_READ_ONLY;
            end
          end else if (objSubindex >= 8'h01 && objSubindex <= JERK_COUNT) begin
            st_nxt.rdData = jerkVal[objSubindex[1:0] - 2'h1];
          end else begin
            st_nxt.answer = ANS_NO_OBJECT;
          end
        end
        IDX_POS_UNIT: begin
          st_nxt.rdData = st_r.posUnit;
          if (objWrite) begin
            st_nxt.posUnit = objWrData & POS_UNIT_MASK;
          end
        end
        IDX_VEL_UNIT: begin
          st_nxt.rdData = st_r.velUnit;
          if (objWrite) begin
            st_nxt.velUnit = objWrData & VEL_UNIT_MASK;
          end
        end
        IDX_POS_OFFSET: begin
          st_nxt.rdData = st_r.posOffset;
          if (objWrite) begin
            st_nxt.posOffset = objWrData;
          end
        end
        IDX_SPEED_OFFSET: begin
          st_nxt.rdData = st_r.speedOffset;
          if (objWrite) begin
            st_nxt.speedOffset = objWrData;
          end
        end
        IDX_TORQUE_OFFSET: begin
          st_nxt.rdData = {{16{st_r.torqueOffset[15]}}, st_r.torqueOffset};
          if (objWrite) begin
            st_nxt.torqueOffset = objWrData[15:0];
          end
        end
        IDX_INTERP_RECORD: begin
          if (objSubindex == SUB_COUNT) begin
            st_nxt.rdData = {24'h000000, INTERP_COUNT};
            if (objWrite) begin
              st_nxt.answer = ANS_READ_ONLY;
            end
          end else if (objSubindex == SUB_FIRST) begin
            st_nxt.rdData = spPending;
          end else begin
            st_nxt.answer = ANS_NO_OBJECT;
          end
        end
        default: begin
          st_nxt.answer = ANS_NO_OBJECT;
        end
      endcase
    end

    if (pdoWrite) begin
      st_nxt.pAck = 1'b1;
      st_nxt.pAnswer = ANS_OK;
      case (pdoIndex)
        IDX_POS_OFFSET: begin
          st_nxt.posOffset = pdoWrData;
        end
        IDX_SPEED_OFFSET: begin
          st_nxt.speedOffset = pdoWrData;
        end
        IDX_TORQUE_OFFSET: begin
          st_nxt.torqueOffset = pdoWrData[15:0];
        end
        IDX_INTERP_RECORD: begin
          if (pdoSubindex != SUB_FIRST) begin
            st_nxt.pAnswer = ANS_NOT_MAPPABLE;
          end
        end
        IDX_JERK_GROUP, IDX_POS_UNIT, IDX_VEL_UNIT: begin
          st_nxt.pAnswer = ANS_NOT_MAPPABLE;
        end
        default: begin
          st_nxt.pAnswer = ANS_NO_OBJECT;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= '{
        posUnit: POS_UNIT_RESET,
        velUnit: VEL_UNIT_RESET,
        posOffset: OFFSET32_RESET,
        speedOffset: OFFSET32_RESET,
        torqueOffset: TORQUE_OFFSET_RESET,
        ack: 1'b0,
        rdData: 32'h00000000,
        answer: ANS_OK,
        pAck: 1'b0,
        pAnswer: ANS_OK,
        posDemand: 32'h00000000,
        spdDemand: 32'h00000000,
        trqDemand: 16'h0000,
        ipDemand: SETPOINT_RESET,
        jerkUnl: 4'h0,
        jerk0: JERK_RESET,
        jerk1: JERK_RESET,
        jerk2: JERK_RESET,
        jerk3: JERK_RESET
      };
    end else begin
      st_r <= st_nxt;
    end
  end

  assign objAck = st_r.ack;
  assign objRdData = st_r.rdData;
  assign objAnswer = st_r.answer;
  assign pdoAck = st_r.pAck;
  assign pdoAnswer = st_r.pAnswer;
  assign jerkAccelStart = st_r.jerk0;
  assign jerkBrakeStart = st_r.jerk1;
  assign jerkAccelEnd = st_r.jerk2;
  assign jerkBrakeEnd = st_r.jerk3;
  assign jerkUnlimited = st_r.jerkUnl;
  assign posUnitCode = st_r.posUnit[POS_UNIT_CODE_LSB +: 8];
  assign posExponent = st_r.posUnit[POS_EXP_LSB +: 8];
  assign velTimeCode = st_r.velUnit[VEL_TIME_CODE_LSB +: 8];
  assign velPosCode = st_r.velUnit[POS_UNIT_CODE_LSB +: 8];
  assign velExponent = st_r.velUnit[POS_EXP_LSB +: 8];
  assign positionDemand = st_r.posDemand;
  assign speedDemand = st_r.spdDemand;
  assign torqueDemand = st_r.trqDemand;
  assign interpDemand = st_r.ipDemand;

  sequence readCount_s(logic [15:0] idx);
    objRead && objIndex == idx && objSubindex == SUB_COUNT;
  endsequence

  jerk_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    readCount_s(IDX_JERK_GROUP) |=> objAck && objRdData == 32'h00000004)
    else $error("jerk count not four");

  interp_count_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    readCount_s(IDX_INTERP_RECORD) |=> objRdData == 32'h00000001)
    else $error("interpolation count not one");

  jerk_readback_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (objWrite && objIndex == IDX_JERK_GROUP && objSubindex == 8'h01) |=> ##1
    jerkAccelStart == $past(objWrData, 2))
    else $error("jerk entry one not stored");

  unit_reserved_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    st_r.posUnit[15:0] == 16'h0000 && st_r.velUnit[7:0] == 8'h00)
    else $error("reserved unit bits set");

  jerk_no_pdo_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pdoWrite && pdoIndex == IDX_JERK_GROUP) |=> pdoAck && pdoAnswer == ANS_NOT_MAPPABLE
    ##0 $stable(st_r.jerk0) ##1 $stable(jerkAccelStart))
    else $error("jerk accepted process data");

  pos_offset_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $stable(st_r.posOffset) |=> positionDemand == $past(positionSet) + $past(st_r.posOffset))
    else $error("position offset not applied");

  torque_pdo_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (pdoWrite && pdoIndex == IDX_TORQUE_OFFSET && !objWrite) |=>
    st_r.torqueOffset == $past(pdoWrData[15:0]))
    else $error("torque offset not written");

  pos_unit_field_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (objWrite && objIndex == IDX_POS_UNIT) |=> posUnitCode == $past(objWrData[23:16])
    && posExponent == $past(objWrData[31:24]))
    else $error("position unit fields wrong");

endmodule : motion_parameter_objects

// *** tb/fieldbus_master_model.sv ***
// Fieldbus master model: issues service and process data accesses to the object bank.
// Assumes: one-cycle request strobes, answer one cycle after the request is taken.
`timescale 1ns/100ps
module fieldbus_master_model
  import motion_objects_pkg::*;
(
  input wire logic clk_sys,
  input wire logic objAck,
  input wire logic [31:0] objRdData,
  input wire logic [1:0] objAnswer,
  input wire logic pdoAck,
  input wire logic [1:0] pdoAnswer,
  output logic objRead,
  output logic objWrite,
  output logic [15:0] objIndex,
  output logic [7:0] objSubindex,
  output logic [31:0] objWrData,
  output logic pdoWrite,
  output logic [15:0] pdoIndex,
  output logic [7:0] pdoSubindex,
  output logic [31:0] pdoWrData
);
  initial begin
    objRead = 1'b0;
    objWrite = 1'b0;
    objIndex = 16'h0000;
    objSubindex = 8'h00;
    objWrData = 32'h00000000;
    pdoWrite = 1'b0;
    pdoIndex = 16'h0000;
    pdoSubindex = 8'h00;
    pdoWrData = 32'h00000000;
  end

  task automatic svcAccess(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] data, output logic [31:0] rd, output logic [1:0] ans,
      output logic done);
    done = 1'b0;
    @(posedge clk_sys);
    objRead <= ~wr;
    objWrite <= wr;
    objIndex <= idx;
    objSubindex <= sub;
    objWrData <= data;
    @(posedge clk_sys);
    objRead <= 1'b0;
    objWrite <= 1'b0;
    for (int n = 0; n < 4 && !done; n++) begin
      @(posedge clk_sys);
      if (objAck === 1'b1) begin
        rd = objRdData;
        ans = objAnswer;
        done = 1'b1;
      end
    end
    // Released index and write data lines show a changed pattern, not the last value
    objIndex <= ~idx;
    objWrData <= ~data;
  endtask : svcAccess

  task automatic pdoAccess(input logic [15:0] idx, input logic [7:0] sub,
      input logic [31:0] data, output logic [1:0] ans, output logic done);
    done = 1'b0;
    @(posedge clk_sys);
    pdoWrite <= 1'b1;
    pdoIndex <= idx;
    pdoSubindex <= sub;
    pdoWrData <= data;
    @(posedge clk_sys);
    pdoWrite <= 1'b0;
    for (int n = 0; n < 4 && !done; n++) begin
      @(posedge clk_sys);
      if (pdoAck === 1'b1) begin
        ans = pdoAnswer;
        done = 1'b1;
      end
    end
    pdoIndex <= ~idx;
    pdoWrData <= ~data;
  endtask : pdoAccess
endmodule : fieldbus_master_model

// *** tb/tb.sv ***
// Testbench: object accesses through the master model, expected values written as literals in the test.
// Assumes: the design answers within a few cycles; run is bounded by a watchdog.
`timescale 1ns/100ps
module tb
  import motion_objects_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic objRead, objWrite, pdoWrite, objAck, pdoAck;
  logic [15:0] objIndex, pdoIndex;
  logic [7:0] objSubindex, pdoSubindex;
  logic [31:0] objWrData, pdoWrData, objRdData;
  logic [1:0] objAnswer, pdoAnswer;
  logic syncPulse = 1'b0;
  logic [31:0] positionSet = 32'h7fffffff;
  logic [31:0] speedSet = 32'h00000010;
  logic [15:0] torqueSet = 16'h0064;
  logic [31:0] jerkAccelStart, jerkBrakeStart, jerkAccelEnd, jerkBrakeEnd;
  logic [3:0] jerkUnlimited;
  logic [7:0] posUnitCode, posExponent, velTimeCode, velPosCode, velExponent;
  logic [31:0] positionDemand, speedDemand, interpDemand;
  logic [15:0] torqueDemand;
  int failCount = 0;
  int checks = 0;

  always #2 clk_sys = ~clk_sys;

  motion_parameter_objects motion_parameter_objects_inst (.clk_sys(clk_sys),
    .sys_rst(sys_rst), .objRead(objRead), .objWrite(objWrite), .objIndex(objIndex),
    .objSubindex(objSubindex), .objWrData(objWrData), .pdoWrite(pdoWrite),
    .pdoIndex(pdoIndex), .pdoSubindex(pdoSubindex), .pdoWrData(pdoWrData),
    .syncPulse(syncPulse), .positionSet(positionSet), .speedSet(speedSet),
    .torqueSet(torqueSet), .objAck(objAck), .objRdData(objRdData), .objAnswer(objAnswer),
    .pdoAck(pdoAck), .pdoAnswer(pdoAnswer), .jerkAccelStart(jerkAccelStart),
    .jerkBrakeStart(jerkBrakeStart), .jerkAccelEnd(jerkAccelEnd),
    .jerkBrakeEnd(jerkBrakeEnd), .jerkUnlimited(jerkUnlimited), .posUnitCode(posUnitCode),
    .posExponent(posExponent), .velTimeCode(velTimeCode), .velPosCode(velPosCode),
    .velExponent(velExponent), .positionDemand(positionDemand), .speedDemand(speedDemand),
    .torqueDemand(torqueDemand), .interpDemand(interpDemand));

  fieldbus_master_model fieldbus_master_model_inst (.clk_sys(clk_sys), .objAck(objAck),
    .objRdData(objRdData), .objAnswer(objAnswer), .pdoAck(pdoAck), .pdoAnswer(pdoAnswer),
    .objRead(objRead), .objWrite(objWrite), .objIndex(objIndex), .objSubindex(objSubindex),
    .objWrData(objWrData), .pdoWrite(pdoWrite), .pdoIndex(pdoIndex),
    .pdoSubindex(pdoSubindex), .pdoWrData(pdoWrData));

  task automatic summarize();
    if (failCount == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk32

  task automatic chkAns(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] t=%0t answer got=%h exp=%h", $time, got, exp);
    end
  endtask : chkAns

  task automatic hang(input logic done);
    if (!done) begin
      failCount++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
      summarize();
    end
  endtask : hang

  task automatic rd(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] a;
    logic ok;
    fieldbus_master_model_inst.svcAccess(1'b0, idx, sub, 32'h0, d, a, ok);
    hang(ok);
    chkAns(a, ANS_OK);
    chk32(d, exp);
  endtask : rd

  task automatic wr(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data,
      input logic [1:0] expAns);
    logic [31:0] d;
    logic [1:0] a;
    logic ok;
    fieldbus_master_model_inst.svcAccess(1'b1, idx, sub, data, d, a, ok);
    hang(ok);
    chkAns(a, expAns);
  endtask : wr

  task automatic pw(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] data,
      input logic [1:0] expAns);
    logic [1:0] a;
    logic ok;
    fieldbus_master_model_inst.pdoAccess(idx, sub, data, a, ok);
    hang(ok);
    chkAns(a, expAns);
  endtask : pw

  task automatic settle();
    repeat (3) @(posedge clk_sys);
    #1;
  endtask : settle

  initial begin
    repeat (20000) @(posedge clk_sys);
    failCount++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    summarize();
  end

  initial begin
    static logic [31:0] jv [4] = '{32'h00000001, 32'hffffffff, 32'h00000000, 32'h12345678};
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rd(IDX_JERK_GROUP, SUB_COUNT, 32'h00000004);
    for (int s = 1; s <= 4; s++) begin
      rd(IDX_JERK_GROUP, 8'(s), 32'h000003e8);
    end
    rd(IDX_POS_UNIT, SUB_COUNT, 32'hff410000);
    rd(IDX_VEL_UNIT, SUB_COUNT, 32'h00b44700);
    chk32({posExponent, posUnitCode, velTimeCode, velPosCode}, 32'hff4147b4);
    rd(IDX_POS_OFFSET, SUB_COUNT, 32'h00000000);
    rd(IDX_SPEED_OFFSET, SUB_COUNT, 32'h00000000);
    rd(IDX_TORQUE_OFFSET, SUB_COUNT, 32'h00000000);
    rd(IDX_INTERP_RECORD, SUB_COUNT, 32'h00000001);
    rd(IDX_INTERP_RECORD, SUB_FIRST, 32'h00000000);
    chk32({28'h0, jerkUnlimited}, 32'h00000000);
    for (int s = 1; s <= 4; s++) begin
      wr(IDX_JERK_GROUP, 8'(s), jv[s-1], ANS_OK);
    end
    settle();
    chk32(jerkAccelStart, jv[0]);
    chk32(jerkBrakeStart, jv[1]);
    chk32(jerkAccelEnd, jv[2]);
    chk32(jerkBrakeEnd, jv[3]);
    chk32({28'h0, jerkUnlimited}, 32'h00000004);
    rd(IDX_JERK_GROUP, 8'h03, 32'h00000000);
    wr(IDX_JERK_GROUP, 8'h03, 32'h00000005, ANS_OK);
    wr(IDX_JERK_GROUP, SUB_COUNT, 32'h00000007, ANS_READ_ONLY);
    wr(IDX_JERK_GROUP, 8'h05, 32'h00000007, ANS_NO_OBJECT);
    rd(IDX_JERK_GROUP, SUB_COUNT, 32'h00000004);
    settle();
    chk32({28'h0, jerkUnlimited}, 32'h00000000);
    chk32(jerkAccelEnd, 32'h00000005);
    pw(IDX_JERK_GROUP, SUB_FIRST, 32'h00000009, ANS_NOT_MAPPABLE);
    pw(IDX_POS_UNIT, SUB_COUNT, 32'h00000009, ANS_NOT_MAPPABLE);
    pw(16'h6000, SUB_COUNT, 32'h00000009, ANS_NO_OBJECT);
    wr(16'h6000, SUB_COUNT, 32'h00000009, ANS_NO_OBJECT);
    rd(IDX_JERK_GROUP, SUB_FIRST, 32'h00000001);
    wr(IDX_POS_UNIT, SUB_COUNT, 32'hffffffff, ANS_OK);
    wr(IDX_VEL_UNIT, SUB_COUNT, 32'h123456ff, ANS_OK);
    rd(IDX_POS_UNIT, SUB_COUNT, 32'hffff0000);
    rd(IDX_VEL_UNIT, SUB_COUNT, 32'h12345600);
    settle();
    chk32({posExponent, posUnitCode, 16'h0}, 32'hffff0000);
    chk32({velExponent, velPosCode, velTimeCode, 8'h0}, 32'h12345600);
    wr(IDX_POS_OFFSET, SUB_COUNT, 32'h00000001, ANS_OK);
    pw(IDX_SPEED_OFFSET, SUB_COUNT, 32'hffffffe0, ANS_OK);
    pw(IDX_TORQUE_OFFSET, SUB_COUNT, 32'h0000fff6, ANS_OK);
    settle();
    chk32(positionDemand, 32'h80000000);
    chk32(speedDemand, 32'hfffffff0);
    chk32({16'h0, torqueDemand}, 32'h0000005a);
    rd(IDX_TORQUE_OFFSET, SUB_COUNT, 32'hfffffff6);
    rd(IDX_SPEED_OFFSET, SUB_COUNT, 32'hffffffe0);
    @(posedge clk_sys);
    speedSet <= 32'h00000100;
    settle();
    chk32(speedDemand, 32'h000000e0);
    pw(IDX_INTERP_RECORD, SUB_COUNT, 32'h00000002, ANS_NOT_MAPPABLE);
    wr(IDX_INTERP_RECORD, SUB_COUNT, 32'h00000002, ANS_READ_ONLY);
    pw(IDX_INTERP_RECORD, SUB_FIRST, 32'h11223344, ANS_OK);
    settle();
    chk32(interpDemand, 32'h00000000);
    rd(IDX_INTERP_RECORD, SUB_FIRST, 32'h11223344);
    chk32(interpDemand, 32'h00000000);
    @(posedge clk_sys);
    syncPulse <= 1'b1;
    @(posedge clk_sys);
    syncPulse <= 1'b0;
    settle();
    chk32(interpDemand, 32'h11223344);
    wr(IDX_INTERP_RECORD, SUB_FIRST, 32'h80000000, ANS_OK);
    settle();
    chk32(interpDemand, 32'h11223344);
    // Sync lands one cycle after the process data write is taken
    fork
      pw(IDX_INTERP_RECORD, SUB_FIRST, 32'hfedcba98, ANS_OK);
      begin
        repeat (2) @(posedge clk_sys);
        syncPulse <= 1'b1;
        @(posedge clk_sys);
        syncPulse <= 1'b0;
      end
    join
    settle();
    chk32(interpDemand, 32'hfedcba98);
    summarize();
  end
endmodule : tb
